/* File: hw/crps_chan.sv */
`timescale 1ns/10ps
// one channel's pwm timing with phase delay and enable behaviour
module crps_chan
  import crps_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic restart,
  input wire logic enable,
  input wire logic hold,
  input wire logic [4:0] delay,
  input wire logic [15:0] period,
  output logic pwm
);
  logic [15:0] cnt_q;                       // position in period
  logic [20:0] dly_cyc;                     // delay in clock cycles
  logic pwm_q;
  // delay = offset/32 of a period
  assign dly_cyc = (21'(delay) * 21'(period)) >> 5;
  assign pwm = pwm_q;
  // counter restarts on phase edge; reset clears all
  always_ff @(posedge clock)
  begin
    if (!rst_n || clr)
    begin
      cnt_q <= '0;
      pwm_q <= 1'b0;
    end
    else if (restart)
    begin
      cnt_q <= '0;
      pwm_q <= 1'b0;
    end
    else if (!enable && hold)
      pwm_q <= pwm_q;                       // hold last state
    else if (!enable)
      pwm_q <= 1'b0;                        // turn off
    else
    begin
      cnt_q <= (cnt_q + 16'h0001 >= period) ? 16'h0000 : cnt_q + 16'h0001;
      pwm_q <= (21'(cnt_q) == dly_cyc);     // rising edge after delay
    end
  end
endmodule : crps_chan

/* File: hw/crps_dev.sv */
`timescale 1ns/10ps
// Function
// - undervoltage forces channels off, defaults
// - hard reset low holds channels off
// - host holds reset until supplies stable
// - host keeps enable high
// - enable low: channel off or hold
// - hold setting defaults to off
// - all timing from master clock
// - serial clock asynchronous, crossed internally; here the read strobe comes on the master clock, not crossed
// - no serial answer without clock
// - pwm rise delayed offset/32 period
// - phase pulse latches flag, read clears
// - phase edge restarts pwm periods
// - host avoids periodic phase pulses
// - reset falling edge latches flag
// - enable-low flag clears when high, read
module crps_dev
  import crps_pkg::*;
(
  input wire logic clock,                   // master clock
  input wire logic rst_n,                   // block reset, sync, low
  input wire logic supply_ok,               // internal supply monitor
  crps_if.dev pins,                         // control pins from the host
  output logic [7:0] pwm_out                // channel drive
);
  // phase alignment input path
  logic ps_s1_q;                            // first stage, may be unsettled
  logic ps_s2_q;                            // second stage, settled
  logic ps_s3_q;                            // delayed copy for edge detect
  logic ps_rise;                            // one-cycle rising-edge pulse
  // hard reset pin history
  logic hr_q;                               // last hard reset level
  logic hr_fall;                            // high-to-low seen this cycle
  // latched flags
  logic rb_q;                               // hard reset seen
  logic en_q;                               // enable seen low
  logic ps_q;                               // phase pulse seen
  // flag set and clear terms
  logic rb_set;                             // hard reset fell
  logic rb_clr;                             // flag register read
  logic en_set;                             // enable pin low
  logic en_clr;                             // read with enable back high
  logic ps_set;                             // phase edge detected
  logic ps_clr;                             // flag register read
  logic rd_ok;                              // read strobe honoured
  // configuration
  logic [7:0] hold_q;                       // latched hold settings
  logic [7:0] hold_d;                       // next hold settings
  // reset terms
  logic supply_lost;                        // supply monitor reports low
  logic pin_reset;                          // hard reset pin held low
  logic clr;                                // internal reset to channels
  logic flag_rst;                           // reset of the flag latches
  // channel outputs before the output register
  logic [7:0] pwm_w;                        // raw markers per channel
  logic [7:0] pwm_d;                        // next output register value
  // supply loss and the hard reset pin both force the channels off;
  // either one alone is enough, so they are simply or-ed
  assign supply_lost = !supply_ok;
  assign pin_reset = !pins.hard_reset_n;
  assign clr = supply_lost || pin_reset;
  // flags survive the hard reset pin, otherwise its own flag could
  // never be seen; only the supply monitor and block reset clear them
  assign flag_rst = !rst_n || supply_lost;
  // without the master clock nothing here advances, so a read strobe
  // is only honoured while the host reports the clock running; the
  // strobe arrives already on the master clock, so no crossing is left
  assign rd_ok = pins.flag_read && pins.master_clk_ok;
  // edge detect reads the settled stages only
  assign ps_rise = ps_s2_q && !ps_s3_q;
  assign hr_fall = hr_q && pin_reset;
  // a set in the read cycle wins over the clear, so no event is lost
  assign rb_set = hr_fall;
  assign rb_clr = rd_ok;
  assign en_set = !pins.enable;
  // the enable flag only clears once the pin is high again
  assign en_clr = rd_ok && pins.enable;
  assign ps_set = ps_rise;
  assign ps_clr = rd_ok;
  // hold settings fall back to off in any reset
  assign hold_d = clr ? {8{CRPS_HOLD_RST}} : pins.hold_cfg;
  // channel drive is cleared by any reset
  assign pwm_d = clr ? 8'h00 : pwm_w;
  // flags returned to the host, all straight from flops
  assign pins.flags = {ps_q, en_q, rb_q};
  // sync chain; the first stage feeds only the second, the third
  // stage exists solely to find the edge
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ps_s1_q <= 1'b0;
      ps_s2_q <= 1'b0;
      ps_s3_q <= 1'b0;
    end
    else
    begin
      ps_s1_q <= pins.phase_sync;
      ps_s2_q <= ps_s1_q;
      ps_s3_q <= ps_s2_q;
    end
  end
  // hard reset history; starts high, the idle level of the pin, so a
  // pin still held low when the block wakes is reported once
  always_ff @(posedge clock)
  begin
    if (flag_rst)
      hr_q <= 1'b1;
    else
      hr_q <= pins.hard_reset_n;
  end
  // configuration latch; the hold bits only matter while enable is low
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      hold_q <= {8{CRPS_HOLD_RST}};
    else
      hold_q <= hold_d;
  end
  // hard reset seen flag
  always_ff @(posedge clock)
  begin
    if (flag_rst)
      rb_q <= 1'b0;
    else if (rb_set)
      rb_q <= 1'b1;
    else if (rb_clr)
      rb_q <= 1'b0;
  end
  // enable seen low flag; a read while the pin is still low keeps it
  always_ff @(posedge clock)
  begin
    if (flag_rst)
      en_q <= 1'b0;
    else if (en_set)
      en_q <= 1'b1;
    else if (en_clr)
      en_q <= 1'b0;
  end
  // phase pulse seen flag
  always_ff @(posedge clock)
  begin
    if (flag_rst)
      ps_q <= 1'b0;
    else if (ps_set)
      ps_q <= 1'b1;
    else if (ps_clr)
      ps_q <= 1'b0;
  end
  // one timing slice per channel, all on the master clock; a periodic
  // phase pulse keeps restarting every slice, which the host must avoid
  genvar g;
  generate
    for (g = 0; g < CRPS_NCH; g++)
    begin : g_ch
      crps_chan crps_chan_i (
        .clock(clock),
        .rst_n(rst_n),
        .clr(clr),
        .restart(ps_rise),
        .enable(pins.enable),
        .hold(hold_q[g]),
        .delay(pins.phase_delay[g]),
        .period(pins.period),
        .pwm(pwm_w[g])
      );
    end
  endgenerate
  // output register; costs one cycle of latency but keeps the drive
  // free of decode glitches
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      pwm_out <= 8'h00;
    else
      pwm_out <= pwm_d;
  end
  // limitation: the hold setting freezes the slice in place, so a held
  // channel keeps whatever marker level it had when enable fell
  // limitation: the delay is worked out in whole master clock cycles,
  // so a period not divisible by 32 rounds each offset down
  // note: the flag latches ignore the hard reset pin on purpose, the
  // host must still be able to read why the channels went off
endmodule : crps_dev

/* File: hw/crps_host.sv */
`timescale 1ns/10ps
// host side: avalon registers drive the control pins
module crps_host
  import crps_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  crps_if.host pins,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  logic [1:0] ctrl_q;                       // [0] run (reset high), [1] enable
  logic [7:0] hold_q;
  logic ps_q, rd_q, ack_q;
  logic wait_q;                             // registered waitrequest
  logic [31:0] rdata_q;
  // request taken on the first edge, completed on the second
  wire req = (avs_read || avs_write) && !ack_q;
  // writes land only at the edge where waitrequest is seen low
  wire take_wr = avs_write && ack_q;
  wire [31:0] rmux = (avs_address == CRPS_A_CTRL) ? {30'h0, ctrl_q} :
    (avs_address == CRPS_A_HOLD) ? {24'h0, hold_q} :
    (avs_address == CRPS_A_FLAG) ? {29'h0, pins.flags} : 32'h0;
  // reset held low until software releases it after supplies settle
  assign pins.hard_reset_n = ctrl_q[0];
  assign pins.enable = ctrl_q[1];
  assign pins.phase_sync = ps_q;            // single pulse per write
  assign pins.master_clk_ok = 1'b1;
  assign pins.hold_cfg = hold_q;
  assign pins.period = CRPS_PER_RST;
  assign pins.flag_read = rd_q;
  for (genvar g = 0; g < CRPS_NCH; g++)
  begin : g_d
    assign pins.phase_delay[g] = 5'(g * 4);
  end
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  // one-wait-state slave
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ctrl_q <= 2'b00;
      hold_q <= 8'h00;
      ps_q <= 1'b0;
      rd_q <= 1'b0;
      ack_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end
    else
    begin
      ack_q <= req;
      wait_q <= !req;
      ps_q <= take_wr && avs_address == CRPS_A_SYNC;
      // strobe lands on the answer edge, after the data was captured
      rd_q <= req && avs_read && avs_address == CRPS_A_FLAG;
      if (req && avs_read)
        rdata_q <= rmux;
      if (take_wr && avs_address == CRPS_A_CTRL)
        ctrl_q <= avs_writedata[1:0];
      if (take_wr && avs_address == CRPS_A_HOLD)
        hold_q <= avs_writedata[7:0];
    end
  end
endmodule : crps_host

/* File: hw/crps_if.sv */
`timescale 1ns/10ps
// pins between host controller and device control logic
interface crps_if;
  logic hard_reset_n;                       // active-low hard reset pin
  logic enable;                             // active-high enable pin
  logic phase_sync;                         // phase alignment pin
  logic master_clk_ok;                      // master clock running
  logic [7:0] hold_cfg;                     // per-channel hold settings
  logic [4:0] phase_delay [8];              // per-channel delays
  logic [15:0] period;                      // pwm period in clocks
  logic flag_read;                          // flag register read strobe
  logic [2:0] flags;                        // flags returned to host
  modport dev (input hard_reset_n, enable, phase_sync, master_clk_ok,
    hold_cfg, phase_delay, period, flag_read, output flags);
  modport host (output hard_reset_n, enable, phase_sync, master_clk_ok,
    hold_cfg, phase_delay, period, flag_read, input flags);
endinterface : crps_if

/* File: hw/crps_pkg.sv */
package crps_pkg;
  // channel count and field widths
  localparam int CRPS_NCH = 8;
  localparam int CRPS_DLY_W = 5;            // delay in 1/32 of a period
  localparam int CRPS_PER_W = 16;           // pwm period counter width
  localparam logic [15:0] CRPS_PER_RST = 16'h0140; // default period cycles
  localparam logic [4:0] CRPS_DLY_RST = 5'h00;
  localparam logic CRPS_HOLD_RST = 1'b0;    // 0: off when enable low
  // avalon register offsets (byte addresses, host side)
  localparam logic [3:0] CRPS_A_CTRL = 4'h0;   // [0] hard reset, [1] enable
  localparam logic [3:0] CRPS_A_HOLD = 4'h4;   // per-channel hold bits
  localparam logic [3:0] CRPS_A_SYNC = 4'h8;   // write: phase pulse
  localparam logic [3:0] CRPS_A_FLAG = 4'hC;   // read: flags, clears
  // flag field positions
  localparam int CRPS_F_RB = 0;
  localparam int CRPS_F_EN = 1;
  localparam int CRPS_F_PS = 2;
endpackage : crps_pkg

/* File: verification/crps_sva.sv */
`timescale 1ns/10ps
// watches the pins between host and device
module crps_sva (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hard_reset_n,
  input wire logic enable,
  input wire logic phase_sync,
  input wire logic flag_read,
  input wire logic [2:0] flags
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  rb_set_a: assert property ($fell(hard_reset_n) |-> ##[1:4] flags[0])
    else $error("reset flag not set");
  en_set_a: assert property (!enable && hard_reset_n |-> ##[0:4] flags[1])
    else $error("enable flag not set");
  ps_set_a: assert property (phase_sync && hard_reset_n |-> ##[1:5] flags[2])
    else $error("phase flag not set");
  en_keep_a: assert property (!enable && hard_reset_n && flags[1] |=> flags[1])
    else $error("enable flag cleared while low");
  rb_keep_a: assert property (flags[0] && hard_reset_n && !flag_read
    |=> flags[0])
    else $error("reset flag lost");
  rd_clr_a: assert property (flag_read && hard_reset_n |-> ##[1:2] !flags[0])
    else $error("reset flag kept after read");
  sync_pulse_a: assert property (phase_sync |=> !phase_sync)
    else $error("phase pulse too long");
  rd_pulse_a: assert property (flag_read |=> !flag_read)
    else $error("read strobe too long");
  // main scenarios reached
  cover property ($fell(hard_reset_n));
  cover property (phase_sync);
  cover property ($fell(enable));
endmodule : crps_sva

/* File: verification/crps_tb.sv */
`timescale 1ns/10ps
module channel_reset_enable_phase_sync_tb;
  import crps_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic supply_ok = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic avs_waitrequest;
  logic [7:0] pwm_out;
  int n_errors = 0;
  int num_checks = 0;
  int t_rise [8];
  always #2.5 clock = ~clock;
  crps_if crps_if_i ();
  crps_dev crps_dev_i (.clock(clock), .rst_n(rst_n), .supply_ok(supply_ok),
    .pins(crps_if_i.dev), .pwm_out(pwm_out));
  crps_host crps_host_i (.clock(clock), .rst_n(rst_n),
    .pins(crps_if_i.host), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  crps_sva crps_sva_i (.clock(clock), .rst_n(rst_n),
    .hard_reset_n(crps_if_i.hard_reset_n), .enable(crps_if_i.enable),
    .phase_sync(crps_if_i.phase_sync), .flag_read(crps_if_i.flag_read),
    .flags(crps_if_i.flags));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // one avalon access; waits for waitrequest low under a bound
  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
      check(32'h1, 32'h0);
    if (avs_waitrequest !== 1'b0)
      tally_and_finish();
  endtask : bus
  // flag register read with expected flag bits
  task automatic rflag(input logic [2:0] e);
    bus(1'b0, CRPS_A_FLAG, 32'h0);
    check(rd, {29'h0, e});
  endtask : rflag
  // gathers pwm markers over n cycles under a mask
  task automatic watch(input logic [7:0] m, input logic [7:0] e,
    input int n);
    logic [7:0] acc;
    acc = 8'h00;
    // let the output register follow the last write first
    repeat (2) @(posedge clock);
    repeat (n) @(posedge clock) acc |= pwm_out;
    check(32'(acc & m), 32'(e));
  endtask : watch
  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    bus(1'b1, CRPS_A_CTRL, 32'h3);
    bus(1'b0, CRPS_A_FLAG, 32'h0);
    rflag(3'b000);
    watch(8'hFF, 8'hFF, 400);
    bus(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    $display("done: start");
    bus(1'b1, CRPS_A_CTRL, 32'h2);
    watch(8'hFF, 8'h00, 400);
    bus(1'b1, CRPS_A_CTRL, 32'h3);
    rflag(3'b001);
    rflag(3'b000);
    $display("done: hard reset");
    bus(1'b1, CRPS_A_CTRL, 32'h1);
    watch(8'hFF, 8'h00, 400);
    rflag(3'b010);
    rflag(3'b010);
    bus(1'b1, CRPS_A_HOLD, 32'hF0);
    watch(8'h0F, 8'h00, 400);
    bus(1'b1, CRPS_A_CTRL, 32'h3);
    bus(1'b1, CRPS_A_HOLD, 32'h0);
    rflag(3'b010);
    rflag(3'b000);
    $display("done: enable");
    bus(1'b1, CRPS_A_SYNC, 32'h1);
    for (int i = 0; i < 8; i++) t_rise[i] = -1;
    for (int c = 0; c < 400; c++)
    begin
      @(posedge clock);
      for (int i = 1; i < 8; i++)
        if (pwm_out[i] === 1'b1 && t_rise[i] < 0 && c >= 8) t_rise[i] = c;
    end
    check(32'(t_rise[1] >= 41 && t_rise[1] <= 46), 32'h1);
    for (int i = 2; i < 8; i++)
      check(32'(t_rise[i] - t_rise[1]),
        32'((i - 1) * 4 * int'(CRPS_PER_RST) / 32));
    rflag(3'b100);
    rflag(3'b000);
    $display("done: phase");
    bus(1'b1, CRPS_A_SYNC, 32'h1);
    repeat (8) @(posedge clock);
    supply_ok <= 1'b0;
    watch(8'hFF, 8'h00, 400);
    supply_ok <= 1'b1;
    rflag(3'b000);
    $display("done: supply");
    tally_and_finish();
  end
endmodule : channel_reset_enable_phase_sync_tb
